// ### rtl/ssp_port.sv
`timescale 1ns/1ns
module ssp_port (
    input  wire logic                          clk_i,
    input  wire logic                          srst_i,
    input  wire logic                          enable_i,
    input  wire ssp_pkg::ssp_cfg_t             cfg_i,
    input  wire logic                          tx_wr_i,
    input  wire logic [31:0]                   tx_data_i,
    output logic                               tx_accept_o,
    output logic                               tx_full_o,
    input  wire logic                          rx_rd_i,
    output logic                               rx_valid_o,
    output logic [31:0]                        rx_data_o,
    output logic                               rx_empty_o,
    output logic                               rx_count_o,
    input  wire logic [ssp_pkg::SSP_IRQ_N-1:0] irq_en_i,
    input  wire logic [ssp_pkg::SSP_IRQ_N-1:0] irq_clr_i,
    output logic      [ssp_pkg::SSP_IRQ_N-1:0] irq_raw_o,
    output logic      [ssp_pkg::SSP_IRQ_N-1:0] irq_masked_o,
    output logic                               irq_o,
    output logic                               dma_tx_req_o,
    output logic                               dma_rx_req_o,
    output logic                               busy_o,
    output logic                               sclk_o,
    output logic                               sclk_oe_o,
    output logic                               fss_o,
    output logic                               fss_oe_o,
    output logic                               txd_o,
    output logic                               txd_oe_o,
    input  wire logic                          sclk_i,
    input  wire logic                          fss_i,
    input  wire logic                          rxd_i
);
    import ssp_pkg::*;

    // ****************************************************
    // Configuration decode
    // ****************************************************
    typedef enum logic [3:0] {
        SSP_IDLE  = 4'b0001,
        SSP_LOAD  = 4'b0010,
        SSP_SHIFT = 4'b0100,
        SSP_GAP   = 4'b1000
    } ssp_state_t;

    function automatic logic [15:0] ssp_width_mask(input logic [4:0] w);
        logic [16:0] m;
        m = (17'h00001 << w) - 17'h00001;
        return m[15:0];
    endfunction : ssp_width_mask

    logic       is_master;
    logic       is_spi;
    logic       is_pulse;
    logic       cpol;
    logic       cpha;
    logic [4:0] width;
    logic [15:0] wmask;

    assign is_master = (cfg_i.role == SSP_MASTER_ROLE);             // [RQ5]
    assign is_spi    = !cfg_i.format[2];                            // [RQ1]
    assign is_pulse  = (cfg_i.format == SSP_FRAMED_PULSE_FORMAT);   // [RQ1]
    assign cpol      = is_spi && cfg_i.format[1];                   // [RQ7]
    assign cpha      = is_spi && cfg_i.format[0];                   // [RQ7]
    // Out-of-range widths are clamped rather than trusted
    assign width = (cfg_i.width < SSP_WIDTH_MIN) ? SSP_WIDTH_MIN :
                   (cfg_i.width > SSP_WIDTH_MAX) ? SSP_WIDTH_MAX :
                   cfg_i.width;                                     // [RQ2]
    assign wmask = ssp_width_mask(width);

    // ****************************************************
    // FIFOs
    // ****************************************************
    logic [15:0] txf_rdata;
    logic        txf_empty;
    logic        txf_full;
    logic [3:0]  txf_level;
    logic        txf_rd;
    logic [15:0] rxf_wdata;
    logic        rxf_wr;
    logic        rxf_empty;
    logic        rxf_full;
    logic [3:0]  rxf_level;
    logic [15:0] rxf_rdata;
    logic        rx_rd_ok;

    ssp_fifo #(.WIDTH(SSP_WORD_W), .DEPTH(SSP_FIFO_DEPTH)) u_txf (  // [RQ3]
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .flush_i (1'b0),
        .wr_i    (tx_wr_i),
        .wdata_i (tx_data_i[15:0] & wmask),                        // [RQ11]
        .rd_i    (txf_rd),
        .rdata_o (txf_rdata),
        .empty_o (txf_empty),
        .full_o  (txf_full),
        .level_o (txf_level)
    );

    ssp_fifo #(.WIDTH(SSP_WORD_W), .DEPTH(SSP_FIFO_DEPTH)) u_rxf (  // [RQ3]
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .flush_i (1'b0),
        .wr_i    (rxf_wr),
        .wdata_i (rxf_wdata),
        .rd_i    (rx_rd_ok),
        .rdata_o (rxf_rdata),
        .empty_o (rxf_empty),
        .full_o  (rxf_full),
        .level_o (rxf_level)
    );

    assign tx_full_o   = txf_full;                                  // [RQ14]
    assign tx_accept_o = tx_wr_i && !txf_full;                      // [RQ14]
    assign rx_empty_o  = rxf_empty;                                 // [RQ13]
    assign rx_count_o  = rx_rd_i && !rxf_empty;                     // [RQ13]
    assign rx_rd_ok    = rx_rd_i && !rxf_empty;

    always_ff @(posedge clk_i) begin
        if (srst_i) rx_valid_o <= 1'b0;
        else        rx_valid_o <= rx_rd_ok;
    end
    // Upper bits are zero since stored words are right-justified
    assign rx_data_o = {16'h0000, rxf_rdata};                       // [RQ10] [RQ19]

    assign dma_tx_req_o = enable_i && (txf_level <= {1'b0, SSP_HALF_LEVEL}); // [RQ12]
    assign dma_rx_req_o = enable_i && !rxf_empty;                   // [RQ12]

    // ****************************************************
    // Master clock generation
    // ****************************************************
    logic [7:0] pre_ff;
    logic [7:0] div_ff;
    logic       tick;  // One half bit period elapsed
    logic       pre_tick;

    assign pre_tick = (pre_ff >= (cfg_i.prescale - 8'h01)) ||
                      (cfg_i.prescale < SSP_PRESC_RST);
    // Half-period ticks keep the bit rate at most clk/2
    always_ff @(posedge clk_i) begin
        if (srst_i || !enable_i) begin
            pre_ff <= '0;
            div_ff <= '0;
        end else if (pre_tick) begin                                // [RQ6]
            pre_ff <= '0;
            div_ff <= (div_ff >= cfg_i.rate_div) ? 8'h00 : div_ff + 8'h01;
        end else begin
            pre_ff <= pre_ff + 8'h01;
        end
    end
    assign tick = pre_tick && (div_ff >= cfg_i.rate_div);           // [RQ6] [RQ8]

    // ****************************************************
    // Input pin sampling
    // ****************************************************
    logic [2:0] pins;
    logic       sclk_q_ff;
    logic       s_sclk;
    logic       s_fss;
    logic       s_rxd;

    ssp_sync #(.N(3)) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .pin_i   ({sclk_i, fss_i, rxd_i}),
        .level_o (pins)
    );
    assign {s_sclk, s_fss, s_rxd} = pins;                           // [RQ9]

    always_ff @(posedge clk_i) begin
        if (srst_i) sclk_q_ff <= 1'b0;
        else        sclk_q_ff <= s_sclk;
    end

    // ****************************************************
    // Shift engine
    // ****************************************************
    ssp_state_t  st_ff;
    logic [15:0] tsh_ff;
    logic [15:0] rsh_ff;
    logic [4:0]  cnt_ff;
    logic        ph_ff;    // Master: 0 = leading half, 1 = trailing half
    logic        sck_ff;
    logic        fs_ff;
    logic        lead_e;
    logic        trail_e;
    logic        samp_e;
    logic        drv_e;
    logic        s_act;

    // Edges relative to idle level: leading edge leaves idle
    always_comb begin
        lead_e  = 1'b0;
        trail_e = 1'b0;
        if (is_master) begin
            lead_e  = (st_ff == SSP_SHIFT) && tick && !ph_ff;
            trail_e = (st_ff == SSP_SHIFT) && tick && ph_ff;
        end else begin
            lead_e  = (st_ff == SSP_SHIFT) && (s_sclk != sclk_q_ff) &&
                      (sclk_q_ff == cpol);
            trail_e = (st_ff == SSP_SHIFT) && (s_sclk != sclk_q_ff) &&
                      (sclk_q_ff != cpol);
        end
        // Phase 0 and the other formats sample on the leading edge
        samp_e = cpha ? trail_e : lead_e;
        drv_e  = cpha ? lead_e : trail_e;
    end

    // Slave frame: SPI select is active low; pulse format starts on a
    // one-clock high pulse; command format uses active-low select
    assign s_act = is_pulse ? s_fss : !s_fss;

    assign txf_rd = (st_ff == SSP_LOAD) && !txf_empty;              // [RQ4]

    always_ff @(posedge clk_i) begin
        if (srst_i || !enable_i) begin
            st_ff  <= SSP_IDLE;
            tsh_ff <= '0;
            rsh_ff <= '0;
            cnt_ff <= '0;
            ph_ff  <= 1'b0;
        end else begin
            case (st_ff)
                SSP_IDLE: begin
                    if ((is_master && !txf_empty) || (!is_master && s_act)) begin
                        st_ff <= SSP_LOAD;
                    end
                end
                SSP_LOAD: begin
                    // Slave with nothing queued sends zeros
                    tsh_ff <= txf_empty ? 16'h0000 : txf_rdata;
                    cnt_ff <= '0;
                    ph_ff  <= 1'b0;
                    st_ff  <= txf_empty ? SSP_SHIFT : SSP_LOAD;
                    if (txf_rd) st_ff <= SSP_GAP;
                end
                SSP_GAP: begin
                    // Registered FIFO data lands here; a master also waits
                    // one tick so the pin synchroniser holds the first bit
                    tsh_ff <= txf_rdata << (5'h10 - width);
                    if (!is_master || tick) st_ff <= SSP_SHIFT;     // [RQ4]
                end
                SSP_SHIFT: begin
                    if (is_master && tick) ph_ff <= !ph_ff;
                    if (samp_e) begin                               // [RQ4]
                        rsh_ff <= {rsh_ff[14:0], is_master ? s_rxd : s_rxd};
                        cnt_ff <= cnt_ff + 5'h01;
                    end
                    if (drv_e && cnt_ff != 5'h00) begin
                        tsh_ff <= {tsh_ff[14:0], 1'b0};
                    end
                    if (trail_e && cnt_ff == width) begin
                        st_ff <= SSP_IDLE;
                    end
                    if (!is_master && !s_act && !is_pulse) begin
                        st_ff <= SSP_IDLE;
                    end
                end
                default: st_ff <= SSP_IDLE;
            endcase
        end
    end

    // Word completes after N sampled bits, right-justified
    assign rxf_wr    = (st_ff == SSP_SHIFT) && trail_e && (cnt_ff == width); // [RQ4]
    assign rxf_wdata = rsh_ff & wmask;                              // [RQ19]

    always_ff @(posedge clk_i) begin
        if (srst_i || !enable_i) begin
            sck_ff <= 1'b0;
            // Select idles inactive so enabling makes no false frame
            fs_ff  <= !is_pulse;
        end else begin
            sck_ff <= (st_ff == SSP_SHIFT) ? (sck_ff ^ (is_master && tick))
                                          : cpol;                   // [RQ7]
            fs_ff  <= is_pulse ? (st_ff == SSP_GAP)
                               : !(st_ff == SSP_SHIFT || st_ff == SSP_GAP);
        end
    end

    assign busy_o    = (st_ff != SSP_IDLE) || !txf_empty;
    assign sclk_o    = sck_ff;
    assign sclk_oe_o = enable_i && is_master;
    assign fss_o     = fs_ff;
    assign fss_oe_o  = enable_i && is_master;
    assign txd_o     = tsh_ff[15];
    assign txd_oe_o  = enable_i &&
                       (cfg_i.role != SSP_SLAVE_ROLE_OUTPUT_OFF) && // [RQ18]
                       (is_master || (st_ff == SSP_SHIFT));

    // ****************************************************
    // Interrupt status
    // ****************************************************
    logic [15:0] to_ff;
    logic [SSP_IRQ_N-1:0] ev;
    logic [SSP_IRQ_N-1:0] sticky_ff;

    always_ff @(posedge clk_i) begin
        if (srst_i || rxf_empty || rxf_wr || rx_rd_ok) to_ff <= '0;
        else if (to_ff != SSP_RXTO_CYCLES) to_ff <= to_ff + 16'h0001;
    end

    always_comb begin
        ev = '0;
        ev[SSP_IRQ_RXTO] = (to_ff == SSP_RXTO_CYCLES - 16'h0001);
        ev[SSP_IRQ_RXOR] = rxf_wr && rxf_full;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) sticky_ff <= '0;
        else        sticky_ff <= (sticky_ff & ~irq_clr_i) | ev;
    end

    always_comb begin
        irq_raw_o = sticky_ff;                                      // [RQ16]
        irq_raw_o[SSP_IRQ_TXFF] = txf_level <= {1'b0, SSP_HALF_LEVEL};
        irq_raw_o[SSP_IRQ_RXFF] = rxf_level >= {1'b0, SSP_HALF_LEVEL};
    end
    assign irq_masked_o = irq_raw_o & irq_en_i;                     // [RQ15] [RQ16]
    assign irq_o        = |irq_masked_o;                            // [RQ15]
endmodule : ssp_port

// ### rtl/ssp_pkg.sv
// Notes on behaviour
// RQ1: Frame format selects one of four SPI variants or two other formats.
// RQ2: Bits per frame are programmable from four to sixteen inclusive.
// RQ3: Separate independent eight-word, sixteen-bit FIFOs for transmit and receive.
// RQ4: Incoming bits become receive words; transmit words are shifted out.
// RQ5: Roles are master, slave, and slave with serial output disabled.
// RQ6: Master serial clock comes from a prescaler then a bit rate divider.
// RQ7: Variants 0..3 map to polarity/phase 00, 01, 10, 11.
// RQ8: As master, the input clock is at least twice the bit rate.
// RQ9: An external master clocks at most one twelfth of our clock.
// RQ10: Read words carry valid data only in their lowest N bits.
// RQ11: Bits above the frame width are ignored on transmit writes.
// RQ12: DMA request outputs let words move without the processor.
// RQ13: Receive empty is reported so an empty read transfers nothing.
// RQ14: Transmit full is reported so a full write is refused.
// RQ15: Each interrupt source has its own enable gating the interrupt.
// RQ16: Interrupt status is readable raw and masked.
// RQ17: Software configures everything before enabling, disables before changes.
// RQ18: In slave-output-off role the data output stays undriven.
// RQ19: Narrow receive words are right-justified, upper bits zero.
package ssp_pkg;
    // ****************************************************
    // Encodings
    // ****************************************************
    typedef enum logic [2:0] {
        SSP_SPI_VARIANT_POL0_PH0 = 3'h0,
        SSP_SPI_VARIANT_POL0_PH1 = 3'h1,
        SSP_SPI_VARIANT_POL1_PH0 = 3'h2,
        SSP_SPI_VARIANT_POL1_PH1 = 3'h3,
        SSP_FRAMED_PULSE_FORMAT  = 3'h4,
        SSP_HALF_DUPLEX_CMD_FMT  = 3'h5
    } ssp_format_t;

    typedef enum logic [1:0] {
        SSP_MASTER_ROLE           = 2'h0,
        SSP_SLAVE_ROLE            = 2'h1,
        SSP_SLAVE_ROLE_OUTPUT_OFF = 2'h2
    } ssp_role_t;

    typedef struct packed {
        ssp_format_t format;
        ssp_role_t   role;
        logic [4:0]  width;     // Bits per frame, 4..16
        logic [7:0]  prescale;  // Even, 2..254
        logic [7:0]  rate_div;  // Serial clock = clk/(2*prescale*(1+rate_div))
    } ssp_cfg_t;

    // Interrupt source bit positions
    localparam int SSP_IRQ_TXFF  = 0;  // Transmit FIFO half empty or less
    localparam int SSP_IRQ_RXFF  = 1;  // Receive FIFO half full or more
    localparam int SSP_IRQ_RXTO  = 2;  // Receive timeout
    localparam int SSP_IRQ_RXOR  = 3;  // Receive overrun
    localparam int SSP_IRQ_N     = 4;

    localparam int          SSP_FIFO_DEPTH  = 8;
    localparam int          SSP_WORD_W      = 16;
    localparam logic [4:0]  SSP_WIDTH_MIN   = 5'h04;
    localparam logic [4:0]  SSP_WIDTH_MAX   = 5'h10;
    localparam logic [4:0]  SSP_WIDTH_RST   = 5'h08;
    localparam logic [7:0]  SSP_PRESC_RST   = 8'h02;
    // Receive timeout: 1024 clock cycles of idle with data waiting
    localparam logic [15:0] SSP_RXTO_CYCLES = 16'h0400;
    localparam logic [2:0]  SSP_HALF_LEVEL  = 3'h4;
endpackage : ssp_pkg

// ### rtl/ssp_fifo.sv
`timescale 1ns/1ns
// ****************************************************
// Small synchronous FIFO, registered read data
// ****************************************************
module ssp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       flush_i,
    input  wire logic                       wr_i,
    input  wire logic [WIDTH-1:0]           wdata_i,
    input  wire logic                       rd_i,
    output logic      [WIDTH-1:0]           rdata_o,
    output logic                            empty_o,
    output logic                            full_o,
    output logic      [$clog2(DEPTH):0]     level_o
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("ssp_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_ff;
    logic [AW:0]      rp_ff;
    logic             do_wr;
    logic             do_rd;

    assign empty_o = (wp_ff == rp_ff);
    assign full_o  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign level_o = wp_ff - rp_ff;
    assign do_wr   = wr_i && !full_o;
    assign do_rd   = rd_i && !empty_o;

    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wp_ff[AW-1:0]] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || flush_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (do_wr) wp_ff <= wp_ff + 1'b1;
            if (do_rd) rp_ff <= rp_ff + 1'b1;
        end
    end

    // Read data registered: valid the cycle after rd_i
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else if (do_rd) begin
            rdata_o <= mem[rp_ff[AW-1:0]];
        end
    end
endmodule : ssp_fifo

// ### rtl/ssp_sync.sv
`timescale 1ns/1ns
// ****************************************************
// Three-stage pin synchroniser; change taken when stages 2 and 3 agree
// ****************************************************
module ssp_sync #(
    parameter int N = 3
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [N-1:0] pin_i,
    output logic      [N-1:0] level_o
);
    logic [N-1:0] s1_ff;
    logic [N-1:0] s2_ff;
    logic [N-1:0] s3_ff;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            level_o <= '0;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < N; i++) begin
                if (s2_ff[i] == s3_ff[i]) level_o[i] <= s3_ff[i];
            end
        end
    end
endmodule : ssp_sync

// ### bench/ssp_port_monitor.sv
`timescale 1ns/1ns
module ssp_port_monitor
    import ssp_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 srst_i,
    input wire ssp_cfg_t             cfg_i,
    input wire logic                 tx_full_o,
    input wire logic                 tx_accept_o,
    input wire logic                 rx_rd_i,
    input wire logic                 rx_empty_o,
    input wire logic                 rx_count_o,
    input wire logic                 rx_valid_o,
    input wire logic [31:0]          rx_data_o,
    input wire logic [SSP_IRQ_N-1:0] irq_en_i,
    input wire logic [SSP_IRQ_N-1:0] irq_raw_o,
    input wire logic [SSP_IRQ_N-1:0] irq_masked_o,
    input wire logic                 irq_o,
    input wire logic                 dma_rx_req_o,
    input wire logic                 sclk_o,
    input wire logic                 fss_o,
    input wire logic                 txd_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_sclk_rise;
        cfg_i.role == SSP_MASTER_ROLE && $rose(sclk_o);
    endsequence
    sequence s_frame_start;
        cfg_i.role == SSP_MASTER_ROLE &&
        cfg_i.format == SSP_SPI_VARIANT_POL0_PH0 && $fell(fss_o);
    endsequence

    AST_TX_REFUSE: assert property (tx_full_o |-> !tx_accept_o)
        else $error("write accepted while full");
    AST_RX_EMPTY: assert property (
        rx_rd_i && rx_empty_o |-> !rx_count_o ##1 !rx_valid_o)
        else $error("read of empty fifo moved data");
    AST_RX_VALID: assert property (rx_count_o |=> rx_valid_o)
        else $error("accepted read gave no data");
    AST_RX_UPPER: assert property (
        rx_valid_o |-> rx_data_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_RX_NARROW: assert property (
        rx_valid_o |-> (rx_data_o[15:0] >> cfg_i.width) == 16'h0000)
        else $error("read bits above frame width");
    AST_MASKED: assert property (
        irq_masked_o == (irq_raw_o & irq_en_i))
        else $error("masked status not raw and enable");
    AST_IRQ_OUT: assert property (irq_o == |irq_masked_o)
        else $error("interrupt not the or of masked status");
    AST_OUT_OFF: assert property (
        cfg_i.role == SSP_SLAVE_ROLE_OUTPUT_OFF &&
        $past(cfg_i.role) == SSP_SLAVE_ROLE_OUTPUT_OFF |-> !txd_oe_o)
        else $error("data output driven in output-off role");
    AST_SCLK_HALF: assert property (s_sclk_rise |=> sclk_o)
        else $error("serial clock high for one cycle only");
    AST_SEL_POL: assert property (s_frame_start |-> !sclk_o)
        else $error("serial clock not idle low at select");
    AST_DMA_RX: assert property (dma_rx_req_o |-> !rx_empty_o)
        else $error("receive request with empty fifo");
endmodule : ssp_port_monitor

bind ssp_port ssp_port_monitor u_mon (
    .clk_i, .srst_i, .cfg_i, .tx_full_o, .tx_accept_o, .rx_rd_i,
    .rx_empty_o, .rx_count_o, .rx_valid_o, .rx_data_o, .irq_en_i,
    .irq_raw_o, .irq_masked_o, .irq_o, .dma_rx_req_o, .sclk_o,
    .fss_o, .txd_oe_o
);

// ### bench/ssp_slave_model.sv
`timescale 1ns/1ns
module ssp_slave_model (
    input  wire logic        sclk_i,
    input  wire logic        sel_n_i,
    input  wire logic        mosi_i,
    input  wire logic [4:0]  width_i,
    input  wire logic [15:0] word_i,
    output logic             miso_o,
    output logic [15:0]      got_o
);
    int idx;
    initial miso_o = 1'b1;
    initial got_o = 16'h0000;
    // First bit must stand before the first rising edge
    always @(negedge sel_n_i) begin
        got_o = 16'h0000;
        idx = width_i - 1;
        miso_o = word_i[idx];
    end
    always @(posedge sclk_i) if (!sel_n_i) got_o = {got_o[14:0], mosi_i};
    always @(negedge sclk_i) if (!sel_n_i && idx > 0) begin
        idx--;
        miso_o = word_i[idx];
    end
    // Released line shows no stale bit
    always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule : ssp_slave_model

// ### bench/ssp_port_tb.sv
`timescale 1ns/1ns
module ssp_port_tb;
    import ssp_pkg::*;
    logic        clk_i, srst_i, enable_i, tx_wr_i, rx_rd_i;
    logic        tx_accept_o, tx_full_o, rx_valid_o, rx_empty_o;
    logic        rx_count_o, irq_o, dma_tx_req_o, dma_rx_req_o;
    logic        busy_o, sclk_o, sclk_oe_o, fss_o, fss_oe_o;
    logic        txd_o, txd_oe_o, sclk_i, fss_i, rxd_i, oe_seen;
    ssp_cfg_t    cfg_i;
    logic [31:0] tx_data_i, rx_data_o;
    logic [3:0]  irq_en_i, irq_clr_i, irq_raw_o, irq_masked_o;
    logic [15:0] slave_word, got;
    int          miscompares, total_checks;

    ssp_port u_dut (
        .clk_i, .srst_i, .enable_i, .cfg_i, .tx_wr_i, .tx_data_i,
        .tx_accept_o, .tx_full_o, .rx_rd_i, .rx_valid_o, .rx_data_o,
        .rx_empty_o, .rx_count_o, .irq_en_i, .irq_clr_i, .irq_raw_o,
        .irq_masked_o, .irq_o, .dma_tx_req_o, .dma_rx_req_o, .busy_o,
        .sclk_o, .sclk_oe_o, .fss_o, .fss_oe_o, .txd_o, .txd_oe_o,
        .sclk_i, .fss_i, .rxd_i
    );
    ssp_slave_model u_slave (
        .sclk_i  (sclk_o & sclk_oe_o),
        .sel_n_i (fss_o | ~fss_oe_o),
        .mosi_i  (txd_o),
        .width_i (cfg_i.width),
        .word_i  (slave_word),
        .miso_o  (rxd_i),
        .got_o   (got)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (txd_oe_o === 1'b1) oe_seen <= 1'b1;

    task automatic step;
        @(posedge clk_i);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [31:0] exp, got_v);
        total_checks++;
        if (got_v !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got_v);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic do_reset;
        step;
        srst_i = 1'b1;
        enable_i = 1'b0;
        repeat (10) step;
        srst_i = 1'b0;
        step;
    endtask : do_reset

    task automatic t_irq;
        chk("txff raw", 1'b1, irq_raw_o[SSP_IRQ_TXFF]);
        chk("irq off", 1'b0, irq_o);
        irq_en_i = 4'h1;
        #1 chk("masked", 4'h1, irq_masked_o);
        chk("irq on", 1'b1, irq_o);
        irq_en_i = 4'h0;
        $display("test irq done");
    endtask : t_irq

    task automatic t_fill;
        do_reset;
        tx_wr_i = 1'b1;
        for (int i = 0; i < 9; i++) begin
            tx_data_i = 32'(i);
            #2 chk("tx accept", i < 8, tx_accept_o);
            step;
        end
        tx_wr_i = 1'b0;
        chk("tx full", 1'b1, tx_full_o);
        chk("txff raw", 1'b0, irq_raw_o[SSP_IRQ_TXFF]);
        rx_rd_i = 1'b1;
        #2 chk("rx count", 1'b0, rx_count_o);
        step;
        rx_rd_i = 1'b0;
        #2 chk("rx valid", 1'b0, rx_valid_o);
        $display("test fill done");
    endtask : t_fill

    task automatic t_xfer(input logic [4:0] w, input logic [15:0] tx, sl);
        logic [15:0] m;
        int n;
        m = 16'hffff >> (5'h10 - w);
        do_reset;
        cfg_i.width = w;
        slave_word = sl;
        enable_i = 1'b1;
        tx_wr_i = 1'b1;
        tx_data_i = {16'hdead, tx};
        step;
        tx_wr_i = 1'b0;
        n = 0;
        while (rx_empty_o !== 1'b0 && n < 2000) begin
            step;
            n++;
        end
        chk("rx arrived", 1'b0, rx_empty_o);
        chk("dma rx req", 1'b1, dma_rx_req_o);
        chk("dma tx req", 1'b1, dma_tx_req_o);
        chk("slave saw", tx & m, got & m);
        rx_rd_i = 1'b1;
        #2 chk("rx count", 1'b1, rx_count_o);
        step;
        rx_rd_i = 1'b0;
        #2 chk("rx valid", 1'b1, rx_valid_o);
        chk("rx data", sl & m, rx_data_o);
        $display("test transfer width %0d done", w);
    endtask : t_xfer

    task automatic t_off;
        do_reset;
        cfg_i.width = 5'h08;
        cfg_i.role = SSP_SLAVE_ROLE_OUTPUT_OFF;
        enable_i = 1'b1;
        tx_wr_i = 1'b1;
        tx_data_i = 32'h0000_00f0;
        step;
        tx_wr_i = 1'b0;
        oe_seen = 1'b0;
        fss_i = 1'b0;
        repeat (12) step;
        // Twelve cycles a half bit keeps the slave rate limit
        for (int i = 0; i < 16; i++) begin
            sclk_i = ~sclk_i;
            repeat (12) step;
        end
        fss_i = 1'b1;
        repeat (12) step;
        chk("txd enable", 1'b0, oe_seen);
        chk("rx kept", 1'b0, rx_empty_o);
        $display("test output off done");
    endtask : t_off

    initial begin
        {srst_i, tx_wr_i, rx_rd_i, sclk_i, enable_i} = 5'h10;
        fss_i = 1'b1;
        oe_seen = 1'b0;
        tx_data_i = 32'h0;
        irq_en_i = 4'h0;
        irq_clr_i = 4'h0;
        slave_word = 16'h0;
        cfg_i = '{SSP_SPI_VARIANT_POL0_PH0, SSP_MASTER_ROLE,
                  5'h08, 8'h04, 8'h01};
        do_reset;
        t_irq;
        t_fill;
        t_xfer(5'h04, 16'h00a5, 16'h0006);
        t_xfer(5'h10, 16'h9c31, 16'he58a);
        t_xfer(5'h08, 16'habc5, 16'h013c);
        t_off;
        give_verdict;
    end
    initial begin
        #(8 * 20000);
        miscompares++;
        give_verdict;
    end
endmodule : ssp_port_tb
